// *** core/asp_params.svh ***
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH
// ================================
// Register offsets (byte addresses)
`define ASP_OFF_DATA    12'h000
`define ASP_OFF_STATUS  12'h004
`define ASP_OFF_CTRL    12'h008
`define ASP_OFF_FORMAT  12'h00c
`define ASP_OFF_DIVISOR 12'h010
// ================================
// Status bit positions
`define ASP_ST_BUSY     0
`define ASP_ST_RXAVAIL  1
`define ASP_ST_TXFULL   2
`define ASP_ST_TXEMPTY  3
`define ASP_ST_RXFULL   4
`define ASP_ST_RXERR    5
// ================================
// Reset values
`define ASP_CTRL_RST    9'h000
`define ASP_FORMAT_RST  6'h03
`define ASP_DIV_RST     16'h0000
// ================================
// Timing counts in oversampling ticks
`define ASP_TICKS_BIT   4'hf
`define ASP_TICKS_HALF  4'h7
`define ASP_IR_PULSE    4'h2
`endif

// *** core/asp_pkg.sv ***
package asp_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} asp_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} asp_rx_e;
  // Control word: fields in bit order 8..0
  typedef struct packed {
    logic dma_err_stop;
    logic dma_tx_en;
    logic dma_rx_en;
    logic infrared_low_power;
    logic infrared_enable;
    logic break_ctl;
    logic receive_enable;
    logic transmit_enable;
    logic port_enable;
  } asp_ctrl_s;
  // Character format: fields in bit order 5..0
  typedef struct packed {
    logic       stick;
    logic       even;
    logic       parity_en;
    logic       stop_two;
    logic [1:0] wlen;
  } asp_fmt_s;
  // One receive queue entry
  typedef struct packed {
    logic       overrun;
    logic       brk;
    logic       parity_err;
    logic       frame_err;
    logic [7:0] data;
  } asp_rxent_s;
endpackage

// *** core/asp_core.sv ***
`timescale 1ns/1ps
`include "asp_params.svh"
module asp_core
  import asp_pkg::*;
#(
  parameter int TX_DEPTH = 16,
  parameter int RX_DEPTH = 16
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  // Serial line
  input  wire logic        rxd_i,
  output logic             txd_o,
  // DMA requests
  output logic             dma_rx_req_o,
  output logic             dma_tx_req_o
);
  localparam int TAW = $clog2(TX_DEPTH);
  localparam int RAW = $clog2(RX_DEPTH);

  // ================================
  // APB access
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        setup_acc;
  logic        acc;
  logic        wr_data, rd_data, wr_ctrl, wr_fmt, wr_div, wr_stat;
  logic        addr_ok;
  asp_ctrl_s   ctrl_r;
  asp_fmt_s    fmt_r;
  logic [15:0] div_r;
  logic        rx_err_r;
  logic        busy;

  // Pready is registered, so every access takes exactly one wait state
  assign setup_acc = psel_i & penable_i & ~pready_r;
  assign acc       = psel_i & penable_i & pready_r;
  assign addr_ok   = (paddr_i == `ASP_OFF_DATA) | (paddr_i == `ASP_OFF_STATUS) | (paddr_i == `ASP_OFF_CTRL) |
                     (paddr_i == `ASP_OFF_FORMAT) | (paddr_i == `ASP_OFF_DIVISOR);
  assign wr_data   = acc & pwrite_i & (paddr_i == `ASP_OFF_DATA);
  assign rd_data   = acc & ~pwrite_i & (paddr_i == `ASP_OFF_DATA);
  assign wr_stat   = acc & pwrite_i & (paddr_i == `ASP_OFF_STATUS);
  assign wr_ctrl   = acc & pwrite_i & (paddr_i == `ASP_OFF_CTRL);
  assign wr_fmt    = acc & pwrite_i & (paddr_i == `ASP_OFF_FORMAT);
  assign wr_div    = acc & pwrite_i & (paddr_i == `ASP_OFF_DIVISOR);

  // ================================
  // Queues
  logic [7:0]   txq_mem [TX_DEPTH];
  logic [TAW:0] txq_cnt_r;
  logic [TAW-1:0] txq_rd_r, txq_wr_r;
  asp_rxent_s   rxq_mem [RX_DEPTH];
  logic [RAW:0] rxq_cnt_r;
  logic [RAW-1:0] rxq_rd_r, rxq_wr_r;
  logic         txq_full, txq_empty, rxq_full, rxq_empty;
  logic         tx_pop, tx_flush, rx_push, rx_pop;
  asp_rxent_s   rx_ent;

  assign txq_full  = (txq_cnt_r == (TAW+1)'(TX_DEPTH));
  assign txq_empty = (txq_cnt_r == '0);
  assign rxq_full  = (rxq_cnt_r == (RAW+1)'(RX_DEPTH));
  assign rxq_empty = (rxq_cnt_r == '0);
  assign rx_pop    = rd_data & ~rxq_empty;

  // Read mux, sampled in the cycle pready rises
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup_acc;
      pslverr_r <= setup_acc & ~addr_ok;
      if (setup_acc) begin
        unique case (paddr_i)
          `ASP_OFF_DATA:    prdata_r <= rxq_empty ? 32'h0000_0000 : {20'h00000, rxq_mem[rxq_rd_r]};
          `ASP_OFF_STATUS:  prdata_r <= {26'h0000000, rx_err_r, rxq_full, txq_empty, txq_full, ~rxq_empty, busy};
          `ASP_OFF_CTRL:    prdata_r <= {23'h000000, ctrl_r};
          `ASP_OFF_FORMAT:  prdata_r <= {26'h0000000, fmt_r};
          `ASP_OFF_DIVISOR: prdata_r <= {16'h0000, div_r};
          default:          prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= `ASP_CTRL_RST;
      fmt_r  <= `ASP_FORMAT_RST;
      div_r  <= `ASP_DIV_RST;
    end else begin
      if (wr_ctrl) ctrl_r <= pwdata_i[8:0];
      if (wr_fmt)  fmt_r  <= pwdata_i[5:0];
      if (wr_div)  div_r  <= pwdata_i[15:0];
    end
  end

  // ================================
  // Baud tick generator
  logic [15:0] baud_cnt_r;
  logic        tick_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      baud_cnt_r <= 16'h0000;
      tick_r     <= 1'b0;
    end else if (div_r == 16'h0000) begin
      baud_cnt_r <= 16'h0000;
      tick_r     <= 1'b0;
    end else begin
      tick_r     <= (baud_cnt_r >= div_r - 16'h0001);
      baud_cnt_r <= (baud_cnt_r >= div_r - 16'h0001) ? 16'h0000 : baud_cnt_r + 16'h0001;
    end
  end

  // ================================
  // Transmit queue
  // flush at once while port_enable is low; the character in flight still finishes
  assign tx_flush = ~ctrl_r.port_enable;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txq_cnt_r <= '0;
      txq_rd_r  <= '0;
      txq_wr_r  <= '0;
    end else if (tx_flush) begin
      txq_cnt_r <= '0;
      txq_rd_r  <= txq_wr_r;
    end else begin
      // writes to a full queue are dropped
      if (wr_data & ~txq_full) begin
        txq_mem[txq_wr_r] <= pwdata_i[7:0];
        txq_wr_r          <= txq_wr_r + 1'b1;
      end
      if (tx_pop) txq_rd_r <= txq_rd_r + 1'b1;
      txq_cnt_r <= txq_cnt_r + (TAW+1)'(wr_data & ~txq_full) - (TAW+1)'(tx_pop);
    end
  end

  // ================================
  // Transmitter
  asp_tx_e    tx_st_r;
  logic [3:0] tx_tk_r;
  logic [2:0] tx_bit_r;
  logic [7:0] tx_sh_r;
  logic       tx_par_r;
  logic       tx_stop2_r;
  logic       tx_line;
  logic       txd_r;
  logic       tx_bit_end;
  logic [2:0] last_bit;

  assign last_bit   = {1'b1, fmt_r.wlen};
  assign tx_bit_end = tick_r & (tx_tk_r == `ASP_TICKS_BIT);
  assign tx_pop     = (tx_st_r == TX_IDLE) & ~txq_empty & ctrl_r.port_enable & ctrl_r.transmit_enable & tick_r;
  // busy covers queued data and the frame in flight
  assign busy       = (tx_st_r != TX_IDLE) | ~txq_empty;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_st_r    <= TX_IDLE;
      tx_tk_r    <= 4'h0;
      tx_bit_r   <= 3'h0;
      tx_sh_r    <= 8'h00;
      tx_par_r   <= 1'b0;
      tx_stop2_r <= 1'b0;
    end else begin
      if (tick_r && tx_st_r != TX_IDLE) tx_tk_r <= tx_tk_r + 4'h1;
      unique case (tx_st_r)
        TX_IDLE: if (tx_pop) begin
          tx_st_r  <= TX_START;
          tx_tk_r  <= 4'h0;
          tx_bit_r <= 3'h0;
          tx_sh_r  <= txq_mem[txq_rd_r];
          tx_par_r <= fmt_r.stick ? ~fmt_r.even : (^(txq_mem[txq_rd_r] & (8'hff >> (3'h3 - {1'b0, fmt_r.wlen}))) ^ ~fmt_r.even);
        end
        TX_START: if (tx_bit_end) tx_st_r <= TX_DATA;
        TX_DATA: if (tx_bit_end) begin
          tx_sh_r  <= tx_sh_r >> 1;
          tx_bit_r <= tx_bit_r + 3'h1;
          // word length ends the data phase
          if (tx_bit_r == last_bit) tx_st_r <= fmt_r.parity_en ? TX_PARITY : TX_STOP;
          tx_stop2_r <= fmt_r.stop_two;
        end
        TX_PARITY: if (tx_bit_end) tx_st_r <= TX_STOP;
        TX_STOP: if (tx_bit_end) begin
          if (tx_stop2_r) tx_stop2_r <= 1'b0;
          else tx_st_r <= TX_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    tx_line = 1'b1;
    unique case (tx_st_r)
      TX_IDLE:   tx_line = 1'b1;
      TX_START:  tx_line = 1'b0;
      TX_DATA:   tx_line = tx_sh_r[0];
      TX_PARITY: tx_line = tx_par_r;
      TX_STOP:   tx_line = 1'b1;
    endcase
  end

  // infrared encoder pulses each zero bit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txd_r <= 1'b1;
    end else if (ctrl_r.infrared_enable) begin
      txd_r <= ~ctrl_r.break_ctl & ~tx_line & (tx_st_r != TX_IDLE) &
               (ctrl_r.infrared_low_power ? (tx_tk_r == 4'h0) : (tx_tk_r <= `ASP_IR_PULSE));
    end else begin
      txd_r <= tx_line & ~ctrl_r.break_ctl;
    end
  end

  // ================================
  // Receive line conditioning
  logic       rx_s1_r, rx_s2_r, rx_s3_r, rx_lvl_r;
  logic [4:0] ir_hold_r;
  logic       rx_line;
  // Three stages; level moves only when the last two agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_s1_r  <= 1'b1;
      rx_s2_r  <= 1'b1;
      rx_s3_r  <= 1'b1;
      rx_lvl_r <= 1'b1;
    end else begin
      rx_s1_r <= rxd_i;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      if (rx_s2_r == rx_s3_r) rx_lvl_r <= rx_s3_r;
    end
  end

  // infrared decoder stretches a pulse to one bit of zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ir_hold_r <= 5'h00;
    end else if (rx_lvl_r) begin
      ir_hold_r <= 5'h10;
    end else if (tick_r && ir_hold_r != 5'h00) begin
      ir_hold_r <= ir_hold_r - 5'h01;
    end
  end
  assign rx_line = ctrl_r.infrared_enable ? (ir_hold_r == 5'h00) : rx_lvl_r;

  // ================================
  // Receiver
  asp_rx_e    rx_st_r;
  logic [3:0] rx_tk_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic       rx_pe_r, rx_ovr_r, rx_zero_r;
  logic       rx_mid;
  logic [7:0] rx_data;

  assign rx_mid  = tick_r & (rx_tk_r == `ASP_TICKS_BIT);
  assign rx_data = rx_sh_r >> (3'h3 - {1'b0, fmt_r.wlen});
  // status bits travel with the character
  // break is all zero bits with a zero stop bit
  // Parity flop also gathers the data xor, so it only means an error after a parity bit
  assign rx_ent  = '{overrun: rx_ovr_r, brk: rx_zero_r & ~rx_line, parity_err: rx_pe_r & fmt_r.parity_en,
                     frame_err: ~rx_line, data: rx_zero_r & ~rx_line ? 8'h00 : rx_data};
  assign rx_push = (rx_st_r == RX_STOP) & rx_mid;

  // start, parity and stop removed before queuing
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_st_r   <= RX_IDLE;
      rx_tk_r   <= 4'h0;
      rx_bit_r  <= 3'h0;
      rx_sh_r   <= 8'h00;
      rx_pe_r   <= 1'b0;
      rx_zero_r <= 1'b0;
    end else begin
      if (tick_r && rx_st_r != RX_IDLE) rx_tk_r <= rx_tk_r + 4'h1;
      unique case (rx_st_r)
        RX_IDLE: if (tick_r && !rx_line && ctrl_r.port_enable && ctrl_r.receive_enable) begin
          rx_st_r   <= RX_START;
          rx_tk_r   <= 4'h0;
          rx_zero_r <= 1'b1;
        end
        // re-check start at its centre, then align to centres
        RX_START: if (tick_r && rx_tk_r == `ASP_TICKS_HALF) begin
          rx_tk_r  <= 4'h0;
          rx_bit_r <= 3'h0;
          rx_pe_r  <= 1'b0;
          rx_st_r  <= rx_line ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_mid) begin
          rx_sh_r   <= {rx_line, rx_sh_r[7:1]};
          rx_zero_r <= rx_zero_r & ~rx_line;
          rx_pe_r   <= rx_pe_r ^ rx_line;
          rx_bit_r  <= rx_bit_r + 3'h1;
          if (rx_bit_r == last_bit) rx_st_r <= fmt_r.parity_en ? RX_PARITY : RX_STOP;
        end
        RX_PARITY: if (rx_mid) begin
          rx_zero_r <= rx_zero_r & ~rx_line;
          rx_pe_r   <= fmt_r.stick ? (rx_line != ~fmt_r.even) : ((rx_pe_r ^ rx_line) != ~fmt_r.even);
          rx_st_r   <= RX_STOP;
        end
        RX_STOP: if (rx_mid) rx_st_r <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rxq_cnt_r <= '0;
      rxq_rd_r  <= '0;
      rxq_wr_r  <= '0;
    end else begin
      if (rx_push & ~rxq_full) begin
        rxq_mem[rxq_wr_r] <= rx_ent;
        rxq_wr_r          <= rxq_wr_r + 1'b1;
      end
      if (rx_pop) rxq_rd_r <= rxq_rd_r + 1'b1;
      rxq_cnt_r <= rxq_cnt_r + (RAW+1)'(rx_push & ~rxq_full) - (RAW+1)'(rx_pop);
    end
  end

  // Overrun is carried on the next character that fits, since the lost one has no slot
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_ovr_r <= 1'b0;
    end else if (rx_push) begin
      rx_ovr_r <= rxq_full;
    end
  end

  // ================================
  // DMA requests
  logic dma_rx_r, dma_tx_r;
  // Error seen: set wins over a software clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_err_r <= 1'b0;
    end else if (rx_push & (rx_ent.parity_err | rx_ent.frame_err | rx_ent.brk | rx_ent.overrun)) begin
      rx_err_r <= 1'b1;
    end else if (wr_stat & pwdata_i[`ASP_ST_RXERR]) begin
      rx_err_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dma_rx_r <= 1'b0;
      dma_tx_r <= 1'b0;
    end else begin
      dma_rx_r <= ctrl_r.dma_rx_en & ~rxq_empty & ~(ctrl_r.dma_err_stop & rx_err_r);
      dma_tx_r <= ctrl_r.dma_tx_en & ~txq_full & ctrl_r.port_enable;
    end
  end

  assign pready_o     = pready_r;
  assign prdata_o     = prdata_r;
  assign pslverr_o    = pslverr_r;
  assign txd_o        = txd_r;
  assign dma_rx_req_o = dma_rx_r;
  assign dma_tx_req_o = dma_tx_r;
endmodule // asp_core

// *** testbench/asp_core_asserts.sv ***
`timescale 1ns/1ps
`include "asp_params.svh"
// ========
// Pin-level checks on bus answers and line framing
module asp_core_asserts (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // Bus side
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic        pslverr_o,
  // Line and requests
  input wire logic        rxd_i,
  input wire logic        txd_o,
  input wire logic        dma_rx_req_o,
  input wire logic        dma_tx_req_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire mapped = paddr_i inside {`ASP_OFF_DATA, `ASP_OFF_STATUS, `ASP_OFF_CTRL, `ASP_OFF_FORMAT, `ASP_OFF_DIVISOR};
  sequence take_s;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence answer_s;
    pready_o ##1 !pready_o;
  endsequence
  ready_after_a:
    assert property (take_s |=> answer_s) else $error("ready missing after access");
  ready_cause_a:
    assert property (pready_o |-> $past(psel_i && penable_i)) else $error("ready without access");
  // An unmapped read must not leak stale data
  unmapped_err_a:
    assert property (take_s and !mapped && !pwrite_i |=> pslverr_o && prdata_o == 32'h0) else $error("bad unmapped");
  mapped_ok_a:
    assert property (take_s and mapped |=> !pslverr_o) else $error("error on mapped address");
  err_ready_a:
    assert property (pslverr_o |-> pready_o) else $error("error without ready");
  upper_zero_a:
    assert property (pready_o |-> prdata_o[31:12] == 20'h0) else $error("upper read bits set");
  rdata_hold_a:
    assert property (!(psel_i && penable_i) |=> $stable(prdata_o)) else $error("read data moved");
  // Shortest low spell is an infrared gap, still well over half a bit
  low_span_a:
    assert property ($fell(txd_o) |=> !txd_o [*7]) else $error("short low on line");
endmodule // asp_core_asserts
bind asp_core asp_core_asserts u_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o),
  .pslverr_o(pslverr_o), .rxd_i(rxd_i), .txd_o(txd_o), .dma_rx_req_o(dma_rx_req_o), .dma_tx_req_o(dma_tx_req_o));

// *** testbench/asp_line_model.sv ***
`timescale 1ns/1ps
// ========
// Far-end serial device; line rests high between plain frames, low after infrared ones
module asp_line_model #(
  parameter int BITCLK = 16
) (
  input  wire logic clk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  initial rxd_o = 1'b1;
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd_o <= bits[i];
      repeat (BITCLK) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask
  // infrared frames: short high pulse per zero bit, line rests low
  task automatic send_ir(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd_o <= ~bits[i];
      repeat (BITCLK * 3 / 16) @(posedge clk_i);
      rxd_o <= 1'b0;
      repeat (BITCLK - BITCLK * 3 / 16) @(posedge clk_i);
    end
  endtask
  task automatic grab(input int n, output logic [11:0] bits);
    bits = 12'h000;
    @(negedge txd_i);
    repeat (BITCLK / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      if (i > 0) repeat (BITCLK) @(posedge clk_i);
      bits[i] = txd_i;
    end
  endtask
endmodule // asp_line_model

// *** testbench/asp_core_bench.sv ***
`timescale 1ns/1ps
`include "asp_params.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; $display("BAD %0t %h %h", $time, a, b); end end
module asp_core_bench;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, rd;
  logic        pready_o, pslverr_o, txd_o, rxd_i, dma_rx_req_o, dma_tx_req_o, err, prev;
  logic [11:0] fr, got;
  logic [7:0]  seed = 8'h05;
  logic [7:0]  dm;
  logic [5:0]  fmt;
  logic [5:0]  fmts [5] = '{6'h00, 6'h18, 6'h08, 6'h28, 6'h38};
  int          nb, st, cnt, hi;
  int          total_checks = 0;
  int          n_mismatch = 0;
  int          rx_q [$];
  asp_core dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .rxd_i(rxd_i), .txd_o(txd_o), .dma_rx_req_o(dma_rx_req_o), .dma_tx_req_o(dma_tx_req_o));
  asp_line_model #(.BITCLK(16)) lm (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));
  initial forever #4 clk_i = ~clk_i;
  // ========
  // Bus master, frame model and verdict
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic void build(input logic [7:0] d, input int wl, input int pm, input int s, input logic bad);
    logic p;
    d = d & 8'((1 << wl) - 1);
    p = (pm == 1) ? ^d : (pm == 2) ? ~^d : (pm == 3);
    fr = 12'h000;
    nb = 1;
    for (int i = 0; i < wl; i++) begin
      fr[nb] = d[i];
      nb++;
    end
    if (pm != 0) begin
      fr[nb] = p ^ bad;
      nb++;
    end
    fr[nb] = 1'b1;
    fr[nb + 1] = s[0];
    nb += 1 + s;
    dm = d;
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 40);
    if (k >= 40) n_mismatch++;
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdr(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    conclude();
  end
  // ========
  // Scenarios
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rdr(`ASP_OFF_FORMAT); `CHK(rd, 32'h3);
    rdr(`ASP_OFF_CTRL); `CHK(rd, 32'h0);
    apb(1'b1, `ASP_OFF_DIVISOR, 32'h1);
    rdr(`ASP_OFF_DIVISOR); `CHK(rd, 32'h1);
    rdr(12'h014); `CHK({err, rd}, 33'h100000000);
    apb(1'b1, `ASP_OFF_CTRL, 32'h47);
    for (int wl = 0; wl < 4; wl++) for (int pm = 0; pm < 5; pm++) begin
      st = (wl + pm) % 2;
      fmt = fmts[pm] | 6'(wl) | 6'(st << 2);
      apb(1'b1, `ASP_OFF_FORMAT, {26'h0, fmt});
      rdr(`ASP_OFF_FORMAT); `CHK(rd[5:0], fmt);
      seed = lfsr(seed);
      build(seed, wl + 5, pm, st, 1'b0);
      fork
        apb(1'b1, `ASP_OFF_DATA, {24'h0, seed});
        lm.grab(nb, got);
      join
      `CHK(got, fr);
      rdr(`ASP_OFF_STATUS); `CHK(rd[`ASP_ST_BUSY], 1'b1);
      repeat (24) @(posedge clk_i);
      rdr(`ASP_OFF_STATUS); `CHK(rd[`ASP_ST_BUSY], 1'b0);
      lm.send(fr, nb);
      rx_q.push_back(int'(dm));
      repeat (6) @(posedge clk_i);
      `CHK(dma_rx_req_o, 1'b1);
      rdr(`ASP_OFF_STATUS); `CHK(rd[`ASP_ST_RXAVAIL], 1'b1);
      rdr(`ASP_OFF_DATA); `CHK(rd, 32'(rx_q.pop_front()));
      rdr(`ASP_OFF_STATUS); `CHK(rd[`ASP_ST_RXAVAIL], 1'b0);
    end
    rdr(`ASP_OFF_DATA); `CHK(rd, 32'h0);
    apb(1'b1, `ASP_OFF_CTRL, 32'h147);
    build(8'h5a, 8, 4, 1, 1'b1);
    lm.send(fr, nb);
    repeat (6) @(posedge clk_i);
    `CHK(dma_rx_req_o, 1'b0);
    rdr(`ASP_OFF_DATA); `CHK(rd, 32'h25a);
    apb(1'b1, `ASP_OFF_STATUS, 32'h20);
    rdr(`ASP_OFF_STATUS); `CHK(rd[`ASP_ST_RXERR], 1'b0);
    lm.send(12'h000, 11);
    repeat (20) @(posedge clk_i);
    rdr(`ASP_OFF_DATA); `CHK(rd, 32'h500);
    apb(1'b1, `ASP_OFF_CTRL, 32'h4f);
    cnt = 0;
    repeat (2 * 12 * 16) begin
      @(posedge clk_i);
      cnt += txd_o;
    end
    `CHK(cnt, 0);
    apb(1'b1, `ASP_OFF_CTRL, 32'h47);
    @(posedge clk_i);
    `CHK(txd_o, 1'b1);
    apb(1'b1, `ASP_OFF_CTRL, 32'h85);
    @(posedge clk_i);
    `CHK(dma_tx_req_o, 1'b1);
    for (int i = 0; i < 16; i++) begin
      rdr(`ASP_OFF_STATUS);
      if (!rd[`ASP_ST_TXFULL]) apb(1'b1, `ASP_OFF_DATA, 32'(i));
    end
    rdr(`ASP_OFF_STATUS); `CHK(rd[`ASP_ST_TXFULL], 1'b1);
    `CHK(dma_tx_req_o, 1'b0);
    apb(1'b1, `ASP_OFF_CTRL, 32'h0);
    rdr(`ASP_OFF_STATUS); `CHK(rd[3:0], 4'h8);
    apb(1'b1, `ASP_OFF_FORMAT, 32'h3);
    // infrared transmit, normal then low-power pulses
    for (int lp = 0; lp < 2; lp++) begin
      apb(1'b1, `ASP_OFF_CTRL, lp ? 32'h33 : 32'h13);
      // Rest low a while so the first pulse does not cut a short low spell
      repeat (8) @(posedge clk_i);
      `CHK(txd_o, 1'b0);
      cnt = 0;
      hi = 0;
      prev = 1'b0;
      fork
        apb(1'b1, `ASP_OFF_DATA, 32'h0);
        repeat (220) begin
          @(posedge clk_i);
          cnt += (txd_o && !prev);
          hi += txd_o;
          prev = txd_o;
        end
      join
      `CHK(cnt, 9);
      `CHK(hi, lp ? 9 : 27);
    end
    // Line rests low in infrared mode; let the decoder drain before receive is on
    lm.send_ir(12'hfff, 2);
    apb(1'b1, `ASP_OFF_CTRL, 32'h17);
    seed = lfsr(seed);
    build(seed, 8, 0, 0, 1'b0);
    rx_q.push_back(int'(dm));
    lm.send_ir(fr, nb);
    repeat (20) @(posedge clk_i);
    rdr(`ASP_OFF_DATA); `CHK(rd, 32'(rx_q.pop_front()));
    conclude();
  end
endmodule // asp_core_bench
